// ==== logic/tx_idle_marker.sv ====
// One port copy of the transmit idle code insertion and channel marker.
// Assumes host strobes are synchronous to i_mclk; line pins and the
// transmit clock are asynchronous and are synchronised here.
//
// How it works
// RULE1: Every one of the 24 channels owns an 8-bit idle code.
// RULE2: Inserted idle code goes out MSB first, bit 0 last.
// RULE3: Idle codes sit linearly, channel 1 lowest, channel 24 highest.
// RULE4: Enable bit 1 replaces channel data with its code; 0 passes.
// RULE5: Three enable registers, lowest channel of each at bit 0.
// RULE6: Static marker is high or low per channel mark bit.
// RULE7: Three mark registers, lowest channel of each at bit 0.
// RULE8: F-bit mark bit 0 makes marker pulse high during F-bit; code drives it high for mark value 1, in static mode only.
// RULE9: Host writes zero to unused upper bits of F-bit mark.
// RULE10: Format bit 0 selects 64 kbps, 1 selects 56 kbps channels.
// RULE11: Clock mode: gap enable 0 pulses each LSB, 1 gaps clock.
// RULE12: Host keeps unused low bits of gapped clock control zero.
// RULE13: Each port copy answers at port 1 address plus n times 200h.
// RULE14: After reset all codes, enables, marks and controls read zero.
// RULE15: Gapped clock pulses only in channels with select bit set.
// RULE16: In 56 kbps mode the gapped clock skips each LSB.
// RULE17: Substitution and marking follow whole channel slots of frame.
// RULE18: Host updates take effect only at the next channel boundary.
`timescale 1ns/10ps
`include "tx_idle_marker_regs.svh"

module stream_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  input  wire logic             i_mclk,
  input  wire logic             i_nrst,
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  output logic [WIDTH-1:0]      o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
    logic                        ready;
  } fifo_type;

  fifo_type st_r;
  fifo_type st_nxt;
  logic     push;
  logic     pop;

  always_comb begin
    st_nxt = st_r;
    push   = i_in_valid && st_r.ready;
    pop    = i_out_ready && (st_r.count != '0);
    if (push) begin
      st_nxt.mem[st_r.wptr] = i_in_data;
      st_nxt.wptr           = st_r.wptr + 1'b1;
    end
    if (pop) begin
      st_nxt.rptr = st_r.rptr + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.count = st_r.count + 1'b1;
    end else if (pop && !push) begin
      st_nxt.count = st_r.count - 1'b1;
    end
    // Registered so the filling side sees an honest, glitch-free ready
    st_nxt.ready = (st_nxt.count != (AW+1)'(DEPTH));
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r       <= '0;
      st_r.ready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_in_ready  = st_r.ready;
  assign o_out_valid = (st_r.count != '0);
  assign o_out_data  = st_r.mem[st_r.rptr];

endmodule

module tx_idle_marker
  import tx_idle_marker_pkg::*;
#(
  parameter logic [1:0] PORT_NUM = 2'h0
) (
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic [11:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  output logic [7:0]       o_rdata,
  input  wire logic        i_transmit_clock,
  input  wire logic        i_frame_sync,
  input  wire logic        i_backplane_data,
  input  wire logic        i_marker_clock_mode,
  output logic             o_tx_data,
  output logic             o_channel_marker_out,
  output logic             o_stream_ready
);

  port_state_type          st_r;
  port_state_type          st_nxt;
  logic                    rise;
  logic                    fall;
  logic                    hit;
  logic [8:0]              off;
  logic                    in_idle_range;
  logic [4:0]              idx;
  logic [`FIFO_WIDTH-1:0]  fifo_out;
  logic                    fifo_valid;
  logic                    fifo_ready;
  logic                    pop;

  function automatic logic [7:0] read_reg(port_state_type s,
                                          logic [8:0] a);
    logic [7:0] v;
    v = `REG_RESET;
    if (a >= `IDLE_CODE_FIRST && a <= `IDLE_CODE_LAST) begin
      v = s.idle_code[5'(a - `IDLE_CODE_FIRST)];
    end else begin
      case (a)
        `IDLE_EN_CH1_8:     v = s.idle_en[7:0];
        `IDLE_EN_CH9_16:    v = s.idle_en[15:8];
        `IDLE_EN_CH17_24:   v = s.idle_en[23:16];
        `CHAN_MARK_CH1_8:   v = s.mark[7:0];
        `CHAN_MARK_CH9_16:  v = s.mark[15:8];
        `CHAN_MARK_CH17_24: v = s.mark[23:16];
        `GAP_SEL_CH1_8:     v = s.gap_sel[7:0];
        `GAP_SEL_CH9_16:    v = s.gap_sel[15:8];
        `GAP_SEL_CH17_24:   v = s.gap_sel[23:16];
        `CHAN_MARK_FBIT:    v[`FBIT_MARK_BIT] = s.fbit_mark;
        `GAP_SEL_FBIT:      v[`GAP_FBIT_BIT] = s.gap_fbit;
        `GAPPED_CLOCK_CTRL: begin
          v[`FMT56_BIT]  = s.fmt56;
          v[`GAP_EN_BIT] = s.gap_en;
        end
        default:            v = `REG_RESET;
      endcase
    end
    return v;
  endfunction

  // Drain only on a transmit clock falling edge, so the FIFO can fill
  stream_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_nrst      (i_nrst),
    .i_in_data   ({st_r.fs_sync[1], st_r.dat_sync[1]}),
    .i_in_valid  (rise),
    .o_in_ready  (fifo_ready),
    .o_out_data  (fifo_out),
    .o_out_valid (fifo_valid),
    .i_out_ready (fall)
  );

  always_comb begin
    st_nxt        = st_r;
    rise          = st_r.transmit_clock_sync[1] && !st_r.transmit_clock_prev;
    fall          = !st_r.transmit_clock_sync[1] && st_r.transmit_clock_prev;
    pop           = fall && fifo_valid;
    // RULE13: port window decode
    hit           = (i_addr[`PORT_SEL_MSB:`PORT_SEL_LSB] == {1'b0, PORT_NUM});
    off           = i_addr[`PORT_SEL_LSB-1:0];
    in_idle_range = (off >= `IDLE_CODE_FIRST) && (off <= `IDLE_CODE_LAST);
    // RULE3: linear channel index
    idx           = 5'(off - `IDLE_CODE_FIRST);

    // Two flops per asynchronous pin; only the second one is read
    st_nxt.transmit_clock_sync = {st_r.transmit_clock_sync[0], i_transmit_clock};
    st_nxt.transmit_clock_prev = st_r.transmit_clock_sync[1];
    st_nxt.fs_sync   = {st_r.fs_sync[0], i_frame_sync};
    st_nxt.dat_sync  = {st_r.dat_sync[0], i_backplane_data};
    st_nxt.mode_sync = {st_r.mode_sync[0], i_marker_clock_mode};

    if (i_wr_en && hit) begin
      if (in_idle_range) begin
        // RULE1: per-channel code store
        st_nxt.idle_code[idx] = i_wdata;
      end else begin
        case (off)
          // RULE5: enable groups
          `IDLE_EN_CH1_8:     st_nxt.idle_en[7:0]   = i_wdata;
          `IDLE_EN_CH9_16:    st_nxt.idle_en[15:8]  = i_wdata;
          `IDLE_EN_CH17_24:   st_nxt.idle_en[23:16] = i_wdata;
          // RULE7: mark groups
          `CHAN_MARK_CH1_8:   st_nxt.mark[7:0]      = i_wdata;
          `CHAN_MARK_CH9_16:  st_nxt.mark[15:8]     = i_wdata;
          `CHAN_MARK_CH17_24: st_nxt.mark[23:16]    = i_wdata;
          `GAP_SEL_CH1_8:     st_nxt.gap_sel[7:0]   = i_wdata;
          `GAP_SEL_CH9_16:    st_nxt.gap_sel[15:8]  = i_wdata;
          `GAP_SEL_CH17_24:   st_nxt.gap_sel[23:16] = i_wdata;
          // RULE9: upper bits unused
          `CHAN_MARK_FBIT:    st_nxt.fbit_mark = i_wdata[`FBIT_MARK_BIT];
          `GAP_SEL_FBIT:      st_nxt.gap_fbit  = i_wdata[`GAP_FBIT_BIT];
          // RULE12: low bits unused
          `GAPPED_CLOCK_CTRL: begin
            st_nxt.fmt56  = i_wdata[`FMT56_BIT];
            st_nxt.gap_en = i_wdata[`GAP_EN_BIT];
          end
          default: ;
        endcase
      end
    end
    if (i_rd_en) begin
      st_nxt.rdata = hit ? read_reg(st_r, off) : `REG_RESET;
    end

    if (pop) begin
      // RULE17: frame position from sync
      if (fifo_out[1] || (!st_r.in_fbit && st_r.ch == `LAST_CH &&
                          st_r.bitn == `LAST_BIT)) begin
        st_nxt.in_fbit = 1'b1;
        st_nxt.ch      = 5'd0;
        st_nxt.bitn    = 3'd0;
      end else if (st_r.in_fbit) begin
        st_nxt.in_fbit = 1'b0;
        st_nxt.ch      = 5'd0;
        st_nxt.bitn    = 3'd0;
      end else if (st_r.bitn == `LAST_BIT) begin
        st_nxt.ch   = st_r.ch + 5'd1;
        st_nxt.bitn = 3'd0;
      end else begin
        st_nxt.bitn = st_r.bitn + 3'd1;
      end

      // RULE18: settings latched at slot start
      if (st_nxt.in_fbit || st_nxt.bitn == 3'd0) begin
        st_nxt.s_fmt56 = st_r.fmt56;
        if (!st_r.mode_sync[1]) begin
          st_nxt.s_mode = mark_static;
        end else if (st_r.gap_en) begin
          st_nxt.s_mode = mark_gapped;
        end else begin
          st_nxt.s_mode = mark_lsb_pulse;
        end
        if (st_nxt.in_fbit) begin
          // RULE8: F-bit mark
          st_nxt.s_code = `REG_RESET;
          st_nxt.s_en   = 1'b0;
          st_nxt.s_mark = st_r.fbit_mark;
          st_nxt.s_gate = st_r.gap_fbit;
        end else begin
          st_nxt.s_code = st_r.idle_code[st_nxt.ch];
          st_nxt.s_en   = st_r.idle_en[st_nxt.ch];
          st_nxt.s_mark = st_r.mark[st_nxt.ch];
          st_nxt.s_gate = st_r.gap_sel[st_nxt.ch];
        end
      end

      // RULE4: replace or pass
      // RULE2: MSB of code first
      st_nxt.tx_data = st_nxt.s_en ? st_nxt.s_code[`LAST_BIT - st_nxt.bitn]
                                   : fifo_out[0];
    end

    unique case (st_nxt.s_mode)
      // RULE6: static level
      mark_static:    st_nxt.marker = st_nxt.s_mark;
      // RULE11: LSB pulse per channel
      mark_lsb_pulse: st_nxt.marker = !st_nxt.in_fbit &&
                                      st_nxt.bitn == `LAST_BIT &&
                                      st_r.transmit_clock_sync[1];
      // RULE15: gated by select
      // RULE16: 56k skips LSB
      // RULE10: format bit used
      mark_gapped:    st_nxt.marker = st_nxt.s_gate &&
                                      !(st_nxt.s_fmt56 && !st_nxt.in_fbit &&
                                        st_nxt.bitn == `LAST_BIT) &&
                                      st_r.transmit_clock_sync[1];
      default:        st_nxt.marker = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      // RULE14: everything clears
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata              = st_r.rdata;
  assign o_tx_data            = st_r.tx_data;
  assign o_channel_marker_out = st_r.marker;
  assign o_stream_ready       = fifo_ready;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);

  // Substituted bit is the code bit for the current position
  subst_msb_a: assert property ( // RULE2
    $past(pop) && st_r.s_en |->
      o_tx_data == st_r.s_code[`LAST_BIT - st_r.bitn])
    else $error("idle code bit out of order");

  pass_through_a: assert property ( // RULE4
    $past(pop) && !st_r.s_en |-> o_tx_data == $past(fifo_out[0]))
    else $error("backplane bit not passed through");

  code_store_a: assert property ( // RULE3
    i_wr_en && hit && in_idle_range |=>
      st_r.idle_code[$past(idx)] == $past(i_wdata))
    else $error("idle code not stored at its channel");

  static_mark_a: assert property ( // RULE6
    st_r.s_mode == mark_static |-> o_channel_marker_out == st_r.s_mark)
    else $error("static marker level wrong");

  lsb_pulse_a: assert property ( // RULE11
    st_r.s_mode == mark_lsb_pulse && o_channel_marker_out |->
      st_r.bitn == `LAST_BIT && !st_r.in_fbit)
    else $error("lsb pulse outside channel lsb");

  gap_select_a: assert property ( // RULE15
    st_r.s_mode == mark_gapped && !st_r.s_gate |-> !o_channel_marker_out)
    else $error("gapped clock in unselected slot");

  gap_omit_a: assert property ( // RULE16
    st_r.s_mode == mark_gapped && st_r.s_fmt56 && !st_r.in_fbit &&
    st_r.bitn == `LAST_BIT |-> !o_channel_marker_out)
    else $error("56k gapped clock on lsb");

  slot_hold_a: assert property ( // RULE18
    $changed(st_r.s_code) |-> $past(pop) &&
      (st_r.bitn == 3'd0 || st_r.in_fbit))
    else $error("code changed inside a slot");

  frame_align_a: assert property ( // RULE17
    pop && fifo_out[1] |=> st_r.in_fbit && st_r.ch == 5'd0)
    else $error("frame sync not aligned to f-bit");

  ctrl_reserved_a: assert property ( // RULE12
    i_rd_en && hit && off == `GAPPED_CLOCK_CTRL |=> o_rdata[5:0] == 6'h00)
    else $error("unused control bits not zero");

  enable_group_a: assert property ( // RULE5
    i_wr_en && hit && off == `IDLE_EN_CH9_16 |=>
      st_r.idle_en[15:8] == $past(i_wdata))
    else $error("enable group not stored");

  mark_group_a: assert property ( // RULE7
    i_wr_en && hit && off == `CHAN_MARK_CH17_24 |=>
      st_r.mark[23:16] == $past(i_wdata))
    else $error("mark group not stored");

  // F-bit slot takes its level from the F-bit mark, not a channel
  fbit_mark_a: assert property ( // RULE8
    $past(pop) && st_r.in_fbit |-> st_r.s_mark == $past(st_r.fbit_mark))
    else $error("f-bit mark not applied");

  fmt_snapshot_a: assert property ( // RULE10
    $past(pop) && (st_r.in_fbit || st_r.bitn == 3'd0) |->
      st_r.s_fmt56 == $past(st_r.fmt56))
    else $error("format not taken at slot start");

  port_decode_a: assert property ( // RULE13
    i_wr_en && !hit |=> $stable(st_r.idle_code) && $stable(st_r.mark))
    else $error("write to other port landed");

  reset_clear_a: assert property ( // RULE14
    $rose(i_nrst) |-> st_r.idle_code == '0 && st_r.idle_en == '0 &&
      st_r.mark == '0 && !st_r.fbit_mark && !st_r.gap_en && !st_r.fmt56)
    else $error("settings not clear after reset");

  fbit_cov: cover property (pop && fifo_out[1]);
  subst_cov: cover property ($past(pop) && st_r.s_en);
  gapped_cov: cover property (st_r.s_mode == mark_gapped &&
                              o_channel_marker_out);
  full_cov: cover property (!o_stream_ready);

endmodule

// ==== logic/tx_idle_marker_regs.svh ====
// Register offsets, field positions, reset values and counts for one
// port copy of the transmit idle code and channel marker block.
// Assumes the 12-bit host address selects the port in bits 11:9.
`ifndef TX_IDLE_MARKER_REGS_SVH
`define TX_IDLE_MARKER_REGS_SVH

`define IDLE_CODE_FIRST     9'h120
`define IDLE_CODE_LAST      9'h137
`define IDLE_EN_CH1_8       9'h150
`define IDLE_EN_CH9_16      9'h151
`define IDLE_EN_CH17_24     9'h152
`define GAPPED_CLOCK_CTRL   9'h185
`define CHAN_MARK_CH1_8     9'h1c4
`define CHAN_MARK_CH9_16    9'h1c5
`define CHAN_MARK_CH17_24   9'h1c6
`define CHAN_MARK_FBIT      9'h1c7
`define GAP_SEL_CH1_8       9'h1cc
`define GAP_SEL_CH9_16      9'h1cd
`define GAP_SEL_CH17_24     9'h1ce
`define GAP_SEL_FBIT        9'h1cf

`define PORT_SEL_MSB        11
`define PORT_SEL_LSB        9

`define FMT56_BIT           7
`define GAP_EN_BIT          6
`define FBIT_MARK_BIT       0
`define GAP_FBIT_BIT        0

`define REG_RESET           8'h00
`define CHANNELS            24
`define LAST_CH             5'd23
`define LAST_BIT            3'd7
`define FIFO_DEPTH          16
`define FIFO_WIDTH          2

`endif

// ==== logic/tx_idle_marker_pkg.sv ====
// Types shared by the transmit idle code and channel marker block.
// Assumes the constants header sits beside it.
`include "tx_idle_marker_regs.svh"

package tx_idle_marker_pkg;

  typedef enum logic [1:0] {
    mark_static,
    mark_lsb_pulse,
    mark_gapped
  } marker_mode_type;

  typedef struct packed {
    logic [`CHANNELS-1:0][7:0] idle_code;
    logic [`CHANNELS-1:0]      idle_en;
    logic [`CHANNELS-1:0]      mark;
    logic                      fbit_mark;
    logic                      fmt56;
    logic                      gap_en;
    logic [`CHANNELS-1:0]      gap_sel;
    logic                      gap_fbit;
    logic [7:0]                rdata;
    logic [1:0]                transmit_clock_sync;
    logic                      transmit_clock_prev;
    logic [1:0]                fs_sync;
    logic [1:0]                dat_sync;
    logic [1:0]                mode_sync;
    logic                      in_fbit;
    logic [4:0]                ch;
    logic [2:0]                bitn;
    logic [7:0]                s_code;
    logic                      s_en;
    logic                      s_mark;
    logic                      s_gate;
    logic                      s_fmt56;
    marker_mode_type           s_mode;
    logic                      tx_data;
    logic                      marker;
  } port_state_type;

endpackage

// ==== testbench/tdm_source_model.sv ====
// Behavioural TDM source feeding the transmit side of one port.
// Assumes the bench calls send_bit once per bit, back to back.
`timescale 1ns/10ps

module tdm_source_model #(
  parameter int HALF_NS = 400
) (
  output logic o_transmit_clock,
  output logic o_frame_sync,
  output logic o_backplane_data
);
  initial begin
    o_transmit_clock = 1'b0;
    o_frame_sync     = 1'b0;
    o_backplane_data = 1'b0;
  end

  // Data moves only while the clock is low
  task automatic send_bit(input logic fs, input logic d);
    o_frame_sync     = fs;
    o_backplane_data = d;
    #(HALF_NS) o_transmit_clock = 1'b1;
    #(HALF_NS) o_transmit_clock = 1'b0;
  endtask

  // Clock parks low; line never shows a stale bit
  task automatic park();
    o_backplane_data = ~o_backplane_data;
  endtask
endmodule

// ==== testbench/t1_tx_idle_code_and_channel_marker_tb.sv ====
// Self-checking bench for one port of the idle code and marker block.
// Assumes the port 1 window (PORT_NUM 0) and a 10 MHz host clock.
`timescale 1ns/10ps

module t1_tx_idle_code_and_channel_marker_tb;
  typedef struct packed {
    logic v;
    logic d;
    logic m;
  } note_type;

  logic        i_mclk;
  logic        i_nrst;
  logic [11:0] i_addr;
  logic [7:0]  i_wdata;
  logic        i_wr_en;
  logic        i_rd_en;
  logic [7:0]  o_rdata;
  logic        transmit_clock;
  logic        fsync;
  logic        bdata;
  logic        mode;
  logic        o_tx_data;
  logic        o_marker;
  logic        o_stream_ready;
  logic [7:0]  code [24] = '{default: 8'h00};
  logic [23:0] en = '0;
  logic [23:0] mark = '0;
  logic [23:0] gsel = '0;
  logic        fbm = 1'b0;
  logic        gfb = 1'b0;
  logic        fmt = 1'b0;
  logic        gen = 1'b0;
  logic [7:0]  r;
  note_type    q [$];
  int          error_cnt;
  int          tests_run;

  tx_idle_marker #(.PORT_NUM(2'h0)) uut (
    .i_mclk,
    .i_nrst,
    .i_addr,
    .i_wdata,
    .i_wr_en,
    .i_rd_en,
    .o_rdata,
    .i_transmit_clock     (transmit_clock),
    .i_frame_sync         (fsync),
    .i_backplane_data     (bdata),
    .i_marker_clock_mode  (mode),
    .o_tx_data,
    .o_channel_marker_out (o_marker),
    .o_stream_ready
  );

  tdm_source_model src (
    .o_transmit_clock (transmit_clock),
    .o_frame_sync     (fsync),
    .o_backplane_data (bdata)
  );

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    #2;
    i_addr  = a;
    i_wdata = d;
    i_wr_en = 1'b1;
    @(posedge i_mclk);
    #2;
    i_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    #2;
    i_addr  = a;
    i_rd_en = 1'b1;
    @(posedge i_mclk);
    #2;
    i_rd_en = 1'b0;
    d       = o_rdata;
  endtask

  task automatic wrc(input logic [11:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    logic [7:0] got;
    wr(a, d);
    rd(a, got);
    chk_reg(got, e);
  endtask

  task automatic rnd();
    foreach (code[i]) code[i] = 8'($urandom);
    en   = 24'($urandom);
    mark = 24'($urandom);
    gsel = 24'($urandom);
  endtask

  // Unused control bits are always written as zero
  task automatic cfg();
    for (int i = 0; i < 24; i++) begin
      wrc(12'h120 + 12'(i), code[i], code[i]);
    end
    for (int k = 0; k < 3; k++) begin
      wrc(12'h150 + 12'(k), en[k*8+:8], en[k*8+:8]);
      wrc(12'h1c4 + 12'(k), mark[k*8+:8], mark[k*8+:8]);
      wrc(12'h1cc + 12'(k), gsel[k*8+:8], gsel[k*8+:8]);
    end
    wrc(12'h1c7, {7'h0, fbm}, {7'h0, fbm});
    wrc(12'h1cf, {7'h0, gfb}, {7'h0, gfb});
    wrc(12'h185, {fmt, gen, 6'h0}, {fmt, gen, 6'h0});
  endtask

  function automatic note_type expect_bit(input int p, input logic b_in);
    note_type n;
    int       c;
    int       b;
    n = '{v: 1'b1, d: b_in, m: mode ? (gen & gfb) : fbm};
    if (p > 0) begin
      c = (p - 1) / 8;
      b = (p - 1) % 8;
      // first bit sent is code bit 7
      if (en[c]) n.d = code[c][7 - b];
      if (!mode) n.m = mark[c];
      else if (!gen) n.m = (b == 7);
      else n.m = gsel[c] & ~(fmt & (b == 7));
    end
    return n;
  endfunction

  // Two idle bits flush the pipe; their outputs are not judged
  task automatic run_frames(input int n);
    logic     d;
    note_type skip;
    skip = '0;
    q.delete();
    for (int f = 0; f < n; f++) begin
      for (int p = 0; p < 193; p++) begin
        d = 1'($urandom);
        q.push_back(expect_bit(p, d));
        src.send_bit(p == 0, d);
      end
    end
    repeat (2) begin
      q.push_back(skip);
      src.send_bit(1'b0, 1'b0);
    end
    src.park();
  endtask

  // Output of a bit is settled two falling edges after it is driven
  always @(negedge transmit_clock) begin
    note_type n;
    #1;
    if (q.size() > 2) begin
      n = q.pop_front();
      if (n.v) begin
        chk_bit(o_tx_data, n.d);
        chk_bit(o_marker, n.m);
        chk_bit(o_stream_ready, 1'b1);
      end
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    error_cnt++;
    conclude();
  end

  initial begin
    i_nrst    = 1'b0;
    i_addr    = 12'h000;
    i_wdata   = 8'h00;
    i_wr_en   = 1'b0;
    i_rd_en   = 1'b0;
    mode      = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    void'($urandom(9712));
    repeat (20) @(posedge i_mclk);
    #2;
    i_nrst = 1'b1;
    for (int a = 'h100; a < 'h200; a++) begin
      rd(12'(a), r);
      chk_reg(r, 8'h00);
    end
    run_frames(1);
    $display("test reset_defaults done");
    rnd();
    cfg();
    wr(12'h320, 8'hff);
    rd(12'h120, r);
    chk_reg(r, code[0]);
    wrc(12'h1ff, 8'hff, 8'h00);
    // Host never sets the unused bits
    wrc(12'h1c7, 8'h01, 8'h01);
    wrc(12'h185, 8'hc0, 8'hc0);
    $display("test register_access done");
    fbm = 1'b1;
    cfg();
    run_frames(2);
    $display("test idle_and_static_mark done");
    mode = 1'b1;
    cfg();
    run_frames(1);
    $display("test lsb_pulse done");
    rnd();
    gen = 1'b1;
    gfb = 1'b1;
    cfg();
    run_frames(1);
    fmt = 1'b1;
    cfg();
    run_frames(1);
    $display("test gapped_clock done");
    conclude();
  end
endmodule
